//--- rtl/clkgc_pkg.sv
/*
 * Shared constants of the clock generator control and status block:
 * register byte offsets, field positions, reset values and load timing.
 * Assumes a 32-bit Avalon-MM slave port with word-aligned addresses.
 */
`default_nettype none
package clkgc_pkg;
    localparam int ADDR_W = 6;
    // Register byte offsets
    localparam logic [5:0] OFS_CTRL     = 6'h00;
    localparam logic [5:0] OFS_STATUS   = 6'h04;
    localparam logic [5:0] OFS_FLAGS    = 6'h08;
    localparam logic [5:0] OFS_MASK     = 6'h0c;
    localparam logic [5:0] OFS_CFG_BASE = 6'h10;
    // Pending config word indices, at OFS_CFG_BASE + 4 * index
    localparam int CFG_WORDS    = 8;
    localparam int CFG_XPOINT   = 0;
    localparam int CFG_DRIVE    = 1;
    localparam int CFG_PRESCALE = 2;
    localparam int CFG_INDIV    = 3;
    localparam int CFG_FB_RATIO = 4;
    localparam int CFG_FR_NUM   = 5;
    localparam int CFG_FR_DEN   = 6;
    localparam int CFG_OUTDIV   = 7;
    // Control fields
    localparam int CTRL_HARD    = 0;
    localparam int CTRL_SOFT    = 1;
    localparam int CTRL_PINSEL  = 2;
    localparam int CTRL_SEL_LO  = 4;
    localparam int CTRL_XTAL    = 6;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0044;
    // Status fields: signal missing on 0..4, lock lost on 5, ready on 8
    localparam int MON_W        = 6;
    localparam int STAT_LOCK    = 5;
    localparam int STAT_READY   = 8;
    localparam logic [MON_W-1:0] MASK_RESET = 6'h00;
    // Field layout of the drive word
    localparam int DRV_LOWSUP   = 8;
    localparam logic [1:0] DRV_MIN = 2'h1;
    localparam logic [1:0] DRV_LOWSUP_MIN = 2'h2;
    // Output integer divider: even, 2 .. 2^25-2
    localparam int OUTDIV_W     = 25;
    localparam logic [24:0] OUTDIV_MIN = 25'h0000002;
    // Number of outputs and crosspoint sources
    localparam int OUTS         = 4;
    // Nonvolatile store contents, arbitrary defaults
    localparam logic [31:0] NVM_CTRL = 32'h0000_0044;
    localparam logic [31:0] NVM_CFG [CFG_WORDS] = '{
        32'h0000_00e4, 32'h0000_00ff, 32'h0000_0001, 32'h0000_0001,
        32'h0000_0064, 32'h0000_0000, 32'h0000_0001, 32'h0000_0002};
    // Cycles spent per word loaded from the store
    localparam int LOAD_NS      = 80;
    localparam int CLK_MHZ      = 125;
    localparam int LOAD_CYC     = (LOAD_NS * CLK_MHZ + 999) / 1000;
    localparam logic [4:0] LOAD_CYC_C = 5'(LOAD_CYC);
endpackage
`default_nettype wire

//--- rtl/clkgc_control.sv
/*
 * Control and status logic of a multi-output clock generator: load from
 * the nonvolatile store, hard and soft reset, reference selection,
 * crystal mode, divider and crosspoint config, monitors with sticky
 * flags and the alert pin, all behind an Avalon-MM slave.
 * Assumes monitor and pin inputs are asynchronous to clk_sys.
 */
// Chosen here: the Avalon-MM register port and the placing of the registers.
`default_nettype none
// Overview of operation
// - After power-up, defaults load from the nonvolatile store.
// - Bus accesses stall until loading finishes; host waits.
// - Clock outputs stay off until loading completes.
// - Hard reset reloads every register and restarts all logic, bus too.
// - Hard reset comes from the reset pin or the hard reset bit.
// - Soft reset applies pending config without reloading the store.
// - Select pins: 00 input 0, 01 input 1, 10 input 2, 11 crystal.
// - A control bit picks pin or register reference selection.
// - Undriven select pins read high through pull-ups.
// - Monitor signal missing on five inputs and PLL lock lost.
// - Monitor states readable in status; lock lost on a pin.
// - Each status bit has a sticky flag set on assertion.
// - A sticky flag clears only by writing zero to it.
// - Interrupt asserts on status change (here only when an unmasked status bit goes high, not when one clears).
// - Each source has a mask bit blocking its interrupt.
// - Interrupt releases once software clears the causing flags.
// - Crystal or external clock mode; load caps off for external.
// - Output integer divider is even, 2 up to 2^25-2.
// - Crosspoint routes any fractional divider to any output.
// - Frequency plan from input, feedback, fractional, integer dividers.
// - Prescaler on the crystal path for clocks above 54 MHz.
// - Drive code 1 to 3; code 1 refused at lowest supply (here a written code 0 still becomes 1 at lowest supply).
module clkgc_control
    import clkgc_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              reset_n,
    input  wire logic [ADDR_W-1:0] address,
    input  wire logic              read,
    input  wire logic              write,
    input  wire logic [31:0]       writedata,
    output logic      [31:0]       readdata,
    output logic                   waitrequest,
    input  wire logic              hard_reset_pin_n,
    input  wire logic [1:0]        inSelPins,
    input  wire logic [4:0]        signal_missing,
    input  wire logic              lock_lost,
    output logic                   lock_lost_pin_n,
    output logic                   alert_pin_n,
    output logic [OUTS-1:0]        clkOutEnable,
    output logic [1:0]             refSelect,
    output logic                   crystalMode,
    output logic                   loadCapEnable,
    output logic [31:0]            crystal_prescaler,
    output logic [31:0]            inputDivider,
    output logic [31:0]            pll_feedback_ratio,
    output logic [31:0]            fracOutNum,
    output logic [31:0]            fracOutDen,
    output logic [OUTDIV_W-1:0]    outIntDivider,
    output logic [2*OUTS-1:0]      crosspointSel,
    output logic [2*OUTS-1:0]      single_ended_drive_code
);

    typedef enum logic [2:0] {
        LOAD_CLEAR = 3'b001,
        LOAD_WORDS = 3'b010,
        RUN        = 3'b100
    } clkgc_state_type;

    clkgc_state_type       state_q;
    logic [2:0]            loadIdx_q;
    logic [4:0]            loadCnt_q;
    logic [MON_W+2:0]      sync1_q;
    logic [MON_W+2:0]      sync2_q;
    logic [MON_W-1:0]      status_q;
    logic [MON_W-1:0]      stickyFlag_q;
    logic [MON_W-1:0]      mask_q;
    logic [31:0]           ctrl_q;
    logic [31:0]           pend_q [CFG_WORDS];
    logic                  waitReq_q;
    logic [31:0]           rdata_q;
    logic                  hardReq;
    logic                  ready;
    logic                  accept;
    logic                  wrDone;
    logic                  softReq;
    logic [MON_W-1:0]      statusNow;
    logic [MON_W-1:0]      flagClr;
    logic                  cfgHit;
    logic [2:0]            cfgIdx;
    logic [31:0]           rdMux;
    logic [31:0]           wrClean;

    // Pins cross into clk_sys through two flops
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            // Pins idle high, monitors idle clear: no false flag after reset
            sync1_q <= {3'b111, {MON_W{1'b0}}};
            sync2_q <= {3'b111, {MON_W{1'b0}}};
        end else begin
            sync1_q <= {hard_reset_pin_n, inSelPins, lock_lost, signal_missing};
            sync2_q <= sync1_q;
        end
    end

    assign statusNow = sync2_q[MON_W-1:0];
    assign ready     = (state_q == RUN);
    assign accept    = ready && (read || write) && waitReq_q;
    assign wrDone    = ready && write && !waitReq_q;
    assign cfgHit    = (address >= OFS_CFG_BASE) &&
                       (address < 6'(OFS_CFG_BASE + 4 * CFG_WORDS));
    assign cfgIdx    = 3'((address - OFS_CFG_BASE) >> 2);
    assign hardReq   = !sync2_q[MON_W+2] ||
                       (wrDone && address == OFS_CTRL && writedata[CTRL_HARD]);
    assign softReq   = wrDone && address == OFS_CTRL && writedata[CTRL_SOFT];
    assign flagClr   = (wrDone && address == OFS_FLAGS) ? ~writedata[MON_W-1:0] : '0;

    // Load sequence from the nonvolatile store
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_q   <= LOAD_CLEAR;
            loadIdx_q <= 3'h0;
            loadCnt_q <= 5'h00;
        end else if (hardReq) begin
            state_q   <= LOAD_CLEAR;
            loadIdx_q <= 3'h0;
            loadCnt_q <= 5'h00;
        end else begin
            case (state_q)
                LOAD_CLEAR: begin
                    state_q <= LOAD_WORDS;
                end
                LOAD_WORDS: begin
                    if (loadCnt_q == LOAD_CYC_C - 5'h01) begin
                        loadCnt_q <= 5'h00;
                        loadIdx_q <= loadIdx_q + 3'h1;
                        if (loadIdx_q == 3'(CFG_WORDS - 1)) begin
                            state_q <= RUN;
                        end
                    end else begin
                        loadCnt_q <= loadCnt_q + 5'h01;
                    end
                end
                RUN: begin
                    state_q <= RUN;
                end
                default: begin
                    state_q <= LOAD_CLEAR;
                end
            endcase
        end
    end

    // Sanitise config writes: even divider, drive code 0 to 1, code 1 to 2 at lowest supply
    always_comb begin
        wrClean = writedata;
        if (cfgIdx == 3'(CFG_OUTDIV)) begin
            wrClean = {7'h00, writedata[OUTDIV_W-1:1], 1'b0};
            if (wrClean[OUTDIV_W-1:0] < OUTDIV_MIN) begin
                wrClean = {7'h00, OUTDIV_MIN};
            end
        end
        if (cfgIdx == 3'(CFG_DRIVE)) begin
            for (int i = 0; i < OUTS; i++) begin
                if (writedata[2*i +: 2] < DRV_MIN) begin
                    wrClean[2*i +: 2] = DRV_MIN;
                end
                if (writedata[DRV_LOWSUP] && writedata[2*i +: 2] == DRV_MIN) begin
                    wrClean[2*i +: 2] = DRV_LOWSUP_MIN;
                end
            end
        end
    end

    // Pending config words: loaded from the store, written by software
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < CFG_WORDS; i++) begin
                pend_q[i] <= 32'h0000_0000;
            end
        end else if (state_q == LOAD_WORDS) begin
            pend_q[loadIdx_q] <= NVM_CFG[loadIdx_q];
        end else if (wrDone && cfgHit) begin
            pend_q[cfgIdx] <= wrClean;
        end
    end

    // Control word; reset and soft bits read back as zero
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_q <= CTRL_RESET;
        end else if (state_q == LOAD_CLEAR) begin
            ctrl_q <= NVM_CTRL;
        end else if (wrDone && address == OFS_CTRL) begin
            ctrl_q <= writedata & 32'h0000_007c;
        end
    end

    // Active config follows pending on a soft reset or after loading
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            crystal_prescaler  <= 32'h0000_0000;
            inputDivider       <= 32'h0000_0000;
            pll_feedback_ratio <= 32'h0000_0000;
            fracOutNum         <= 32'h0000_0000;
            fracOutDen         <= 32'h0000_0000;
            outIntDivider      <= OUTDIV_MIN;
            crosspointSel      <= '0;
            single_ended_drive_code <= '0;
        end else if (softReq || (state_q == LOAD_WORDS &&
                     loadIdx_q == 3'(CFG_WORDS - 1) && loadCnt_q == LOAD_CYC_C - 5'h01)) begin
            crystal_prescaler  <= pend_q[CFG_PRESCALE];
            inputDivider       <= pend_q[CFG_INDIV];
            pll_feedback_ratio <= pend_q[CFG_FB_RATIO];
            fracOutNum         <= pend_q[CFG_FR_NUM];
            fracOutDen         <= pend_q[CFG_FR_DEN];
            outIntDivider      <= pend_q[CFG_OUTDIV][OUTDIV_W-1:0];
            crosspointSel      <= pend_q[CFG_XPOINT][2*OUTS-1:0];
            single_ended_drive_code <= pend_q[CFG_DRIVE][2*OUTS-1:0];
        end
    end

    // Reference select, crystal mode, output gating
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            refSelect     <= 2'h3;
            crystalMode   <= 1'b1;
            loadCapEnable <= 1'b0;
            clkOutEnable  <= '0;
        end else begin
            if (ctrl_q[CTRL_PINSEL]) begin
                refSelect <= sync2_q[MON_W+1:MON_W];
            end else begin
                refSelect <= ctrl_q[CTRL_SEL_LO +: 2];
            end
            crystalMode   <= ctrl_q[CTRL_XTAL];
            loadCapEnable <= ctrl_q[CTRL_XTAL] && ready;
            clkOutEnable  <= ready ? '1 : '0;
        end
    end

    // Monitors, sticky flags and mask
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            status_q     <= '0;
            stickyFlag_q <= '0;
            mask_q       <= MASK_RESET;
        end else if (state_q == LOAD_CLEAR) begin
            status_q     <= '0;
            stickyFlag_q <= '0;
            mask_q       <= MASK_RESET;
        end else begin
            status_q <= statusNow;
            // Set beats a clear in the same cycle
            stickyFlag_q <= (stickyFlag_q & ~flagClr) |
                            (statusNow & ~status_q);
            if (wrDone && address == OFS_MASK) begin
                mask_q <= writedata[MON_W-1:0];
            end
        end
    end

    // Pins
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            lock_lost_pin_n <= 1'b1;
            alert_pin_n     <= 1'b1;
        end else begin
            lock_lost_pin_n <= !status_q[STAT_LOCK];
            alert_pin_n     <= !(|(stickyFlag_q & ~mask_q));
        end
    end

    always_comb begin
        rdMux = 32'h0000_0000;
        case (address)
            OFS_CTRL:   rdMux = ctrl_q;
            OFS_STATUS: rdMux = {23'h0, ready, 2'h0, status_q};
            OFS_FLAGS:  rdMux = {26'h0, stickyFlag_q};
            OFS_MASK:   rdMux = {26'h0, mask_q};
            default: begin
                if (cfgHit) begin
                    rdMux = pend_q[cfgIdx];
                end
            end
        endcase
    end

    // Avalon-MM answer: waitrequest held high until loaded, one low cycle per access
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            waitReq_q <= 1'b1;
            rdata_q   <= 32'h0000_0000;
        end else if (hardReq || !ready) begin
            waitReq_q <= 1'b1;
            rdata_q   <= 32'h0000_0000;
        end else if (accept) begin
            waitReq_q <= 1'b0;
            rdata_q   <= read ? rdMux : 32'h0000_0000;
        end else begin
            waitReq_q <= 1'b1;
        end
    end

    assign waitrequest = waitReq_q;
    assign readdata    = rdata_q;

endmodule
`default_nettype wire

//--- tb/clkgc_control_monitor.sv
/* Checker of clkgc_control port timing and field legality.
   Assumes one clock domain and the asynchronous active-low reset. */
`default_nettype none
module clkgc_control_monitor
    import clkgc_pkg::*;
(
    input wire logic                clk_sys,
    input wire logic                reset_n,
    input wire logic                read,
    input wire logic                write,
    input wire logic                waitrequest,
    input wire logic                hard_reset_pin_n,
    input wire logic                lock_lost,
    input wire logic                lock_lost_pin_n,
    input wire logic                alert_pin_n,
    input wire logic [OUTS-1:0]     clkOutEnable,
    input wire logic                crystalMode,
    input wire logic                loadCapEnable,
    input wire logic [OUTDIV_W-1:0] outIntDivider,
    input wire logic [2*OUTS-1:0]   single_ended_drive_code
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);
    a_wait_one_low: assert property (!waitrequest |=> waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_load_stall: assert property ((read || write) && clkOutEnable == '0 |-> waitrequest)
        else $error("access answered during load");
    a_clk_run: assert property (!waitrequest |-> clkOutEnable == {OUTS{1'b1}})
        else $error("access answered while clocks are off");
    a_hard_pin: assert property ((!hard_reset_pin_n)[*8] |-> clkOutEnable == '0 && waitrequest)
        else $error("reset pin did not restart the device");
    a_lock_pin: assert property ($stable(lock_lost)[*5] ##0 (clkOutEnable[0]
        && $past(clkOutEnable[0], 5)) |-> lock_lost_pin_n == !lock_lost)
        else $error("lock lost pin does not follow the monitor");
    a_alert_cause: assert property ($rose(alert_pin_n) && clkOutEnable[0] |->
        $past(write && !waitrequest, 2) || $past(write && !waitrequest, 3))
        else $error("alert released without a register write");
    a_caps_xtal: assert property (loadCapEnable |-> crystalMode)
        else $error("load capacitors on in external clock mode");
    a_div_even: assert property (!outIntDivider[0] && outIntDivider >= OUTDIV_MIN)
        else $error("output divider odd or below two");
    a_drive_legal: assert property (clkOutEnable[0] |-> single_ended_drive_code[1:0] != 2'h0
        && single_ended_drive_code[3:2] != 2'h0 && single_ended_drive_code[5:4] != 2'h0
        && single_ended_drive_code[7:6] != 2'h0)
        else $error("drive code zero on an output");
    c_write_taken: cover property (write && !waitrequest);
    c_alert_low: cover property ($fell(alert_pin_n));
    c_lock_low: cover property ($fell(lock_lost_pin_n));
    c_restart: cover property ($fell(clkOutEnable[0]));
endmodule
bind clkgc_control clkgc_control_monitor u_mon (
    .clk_sys(clk_sys), .reset_n(reset_n), .read(read), .write(write),
    .waitrequest(waitrequest), .hard_reset_pin_n(hard_reset_pin_n),
    .lock_lost(lock_lost), .lock_lost_pin_n(lock_lost_pin_n), .alert_pin_n(alert_pin_n),
    .clkOutEnable(clkOutEnable), .crystalMode(crystalMode), .loadCapEnable(loadCapEnable),
    .outIntDivider(outIntDivider), .single_ended_drive_code(single_ended_drive_code));
`default_nettype wire

//--- tb/clkgc_host_model.sv
/* Host controller model: Avalon-MM master for the register port.
   Assumes its tasks are called from a process synchronous to clk_sys. */
`default_nettype none
module clkgc_host_model
    import clkgc_pkg::*;
(
    input  wire logic             clk_sys,
    input  wire logic             waitrequest,
    input  wire logic [31:0]      readdata,
    output var logic [ADDR_W-1:0] address,
    output var logic              read,
    output var logic              write,
    output var logic [31:0]       writedata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        address = '0;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0;
    end
    // Request held until waitrequest is sampled low, even through load
    task automatic access(input logic wr, input logic [ADDR_W-1:0] a,
                          input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_sys);
        address <= a;
        write <= wr;
        read <= !wr;
        writedata <= d;
        do @(posedge clk_sys); while (waitrequest !== 1'b0);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
endmodule
`default_nettype wire

//--- tb/clkgc_control_test.sv
/* Self-checking bench of clkgc_control with a reference model.
   Assumes the host model and the bound checker are compiled alongside. */
`default_nettype none
module clkgc_control_test
    import clkgc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0, reset_n = 1'b0, hard_reset_pin_n = 1'b1, selFloat = 1'b0;
    logic [1:0] selVal = 2'h0;
    logic [5:0] mon = 6'h00;
    tri1  [1:0] inSelPins;
    logic [ADDR_W-1:0] address;
    logic read, write, waitrequest, lock_lost_pin_n, alert_pin_n, crystalMode, loadCapEnable;
    logic [31:0] writedata, readdata, crystal_prescaler, inputDivider, pll_feedback_ratio;
    logic [31:0] fracOutNum, fracOutDen, q;
    logic [OUTS-1:0] clkOutEnable;
    logic [1:0] refSelect;
    logic [OUTDIV_W-1:0] outIntDivider;
    logic [2*OUTS-1:0] crosspointSel, single_ended_drive_code;
    logic [31:0] cfgW [CFG_WORDS];
    logic [31:0] actExp [CFG_WORDS];
    int miscompares = 0, check_count = 0;
    assign inSelPins = selFloat ? 2'bzz : selVal;
    always #4 clk_sys = ~clk_sys;
    clkgc_host_model u_host (.clk_sys(clk_sys), .waitrequest(waitrequest),
        .readdata(readdata), .address(address), .read(read), .write(write),
        .writedata(writedata));
    clkgc_control u_dut (.clk_sys(clk_sys), .reset_n(reset_n), .address(address),
        .read(read), .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .hard_reset_pin_n(hard_reset_pin_n),
        .inSelPins(inSelPins), .signal_missing(mon[4:0]), .lock_lost(mon[5]),
        .lock_lost_pin_n(lock_lost_pin_n), .alert_pin_n(alert_pin_n),
        .clkOutEnable(clkOutEnable), .refSelect(refSelect), .crystalMode(crystalMode),
        .loadCapEnable(loadCapEnable), .crystal_prescaler(crystal_prescaler),
        .inputDivider(inputDivider), .pll_feedback_ratio(pll_feedback_ratio),
        .fracOutNum(fracOutNum), .fracOutDen(fracOutDen), .outIntDivider(outIntDivider),
        .crosspointSel(crosspointSel), .single_ended_drive_code(single_ended_drive_code));
    function automatic logic [31:0] got(int i);
        case (i)
            CFG_XPOINT: return 32'(crosspointSel);
            CFG_DRIVE: return 32'(single_ended_drive_code);
            CFG_PRESCALE: return crystal_prescaler;
            CFG_INDIV: return inputDivider;
            CFG_FB_RATIO: return pll_feedback_ratio;
            CFG_FR_NUM: return fracOutNum;
            CFG_FR_DEN: return fracOutDen;
            default: return 32'(outIntDivider);
        endcase
    endfunction
    // Active value that a pending word should become
    function automatic logic [31:0] legal(int i, logic [31:0] w);
        logic [31:0] r;
        logic [1:0]  c;
        r = (i == CFG_XPOINT) ? {24'h0, w[7:0]} : w;
        if (i == CFG_DRIVE) begin
            r = 32'h0;
            for (int k = 0; k < OUTS; k++) begin
                c = w[2*k +: 2];
                if (c == 2'h0) c = DRV_MIN;
                else if (c == 2'h1 && w[DRV_LOWSUP]) c = DRV_LOWSUP_MIN;
                r[2*k +: 2] = c;
            end
        end
        if (i == CFG_OUTDIV) r = {7'h0, w[24:1], 1'b0};
        if (i == CFG_OUTDIV && r < 32'h2) r = 32'h2;
        return r;
    endfunction
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d);
        u_host.access(1'b0, a, 32'h0, d);
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        logic [31:0] x;
        u_host.access(1'b1, a, d, x);
    endtask
    task automatic settle(int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic chk_act();
        for (int i = 0; i < CFG_WORDS; i++) chk("active cfg", got(i), actExp[i]);
    endtask
    task automatic test_done();
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Watchdog: the sequence needs well under a thousand cycles
    initial begin
        #200000;
        miscompares++;
        test_done();
    end
    initial begin
        q = $urandom(2);
        for (int i = 0; i < CFG_WORDS; i++) actExp[i] = legal(i, NVM_CFG[i]);
        settle(12);
        reset_n <= 1'b1;
        rd(OFS_CTRL, q);
        chk("ctrl", q, NVM_CTRL);
        chk("clocks on", clkOutEnable, 32'hf);
        chk_act();
        rd(OFS_STATUS, q);
        chk("status", q, 32'h1 << STAT_READY);
        for (int r = 0; r < 3; r++) begin
            for (int i = 0; i < CFG_WORDS; i++) cfgW[i] = $urandom;
            cfgW[CFG_DRIVE] = (r == 0) ? cfgW[CFG_DRIVE] & 32'hff : 32'h155 * (2 - r);
            if (r > 0) cfgW[CFG_OUTDIV] = (r == 1) ? 32'h1ffffff : 32'h1;
            for (int i = 0; i < CFG_WORDS; i++) wr(OFS_CFG_BASE + 6'(4 * i), cfgW[i]);
            chk_act();
            wr(OFS_CTRL, NVM_CTRL | (32'h1 << CTRL_SOFT));
            settle(2);
            for (int i = 0; i < CFG_WORDS; i++) actExp[i] = legal(i, cfgW[i]);
            chk_act();
        end
        wr(OFS_CTRL, NVM_CTRL | (32'h1 << CTRL_PINSEL));
        for (int p = 0; p < 4; p++) begin
            selVal <= 2'(p);
            settle(6);
            chk("pin ref", refSelect, 32'(p));
        end
        selFloat <= 1'b1;
        settle(6);
        chk("float ref", refSelect, 32'h3);
        selFloat <= 1'b0;
        for (int p = 0; p < 4; p++) begin
            selVal <= 2'(3 - p);
            wr(OFS_CTRL, 32'(p) << CTRL_SEL_LO);
            settle(2);
            chk("reg ref", refSelect, 32'(p));
            chk("ext mode", {crystalMode, loadCapEnable}, 32'h0);
        end
        wr(OFS_CTRL, NVM_CTRL);
        settle(2);
        chk("xtal mode", {crystalMode, loadCapEnable}, 32'h3);
        for (int i = 0; i < MON_W; i++) begin
            wr(OFS_MASK, (i == 3) ? 32'h8 : 32'h0);
            mon <= 6'(1 << i);
            settle(8);
            rd(OFS_STATUS, q);
            chk("status", q, (32'h1 << i) | (32'h1 << STAT_READY));
            chk("lock pin", lock_lost_pin_n, i != 5);
            chk("alert", alert_pin_n, i == 3);
            mon <= 6'h00;
            settle(8);
            chk("alert held", alert_pin_n, i == 3);
            rd(OFS_FLAGS, q);
            chk("flag held", q, 32'h1 << i);
            wr(OFS_FLAGS, 32'hffffffff);
            rd(OFS_FLAGS, q);
            chk("flag kept", q, 32'h1 << i);
            wr(OFS_FLAGS, ~(32'h1 << i));
            rd(OFS_FLAGS, q);
            chk("flag clear", q, 32'h0);
            chk("alert off", alert_pin_n, 1'b1);
        end
        wr(OFS_STATUS, 32'hffffffff);
        rd(OFS_STATUS, q);
        chk("status ro", q, 32'h1 << STAT_READY);
        rd(6'h30, q);
        chk("unmapped", q, 32'h0);
        for (int i = 0; i < CFG_WORDS; i++) actExp[i] = legal(i, NVM_CFG[i]);
        for (int h = 0; h < 2; h++) begin
            wr(OFS_MASK, 32'h3f);
            mon <= 6'h01;
            settle(8);
            mon <= 6'h00;
            if (h == 0) wr(OFS_CTRL, 32'h1 << CTRL_HARD);
            else begin
                hard_reset_pin_n <= 1'b0;
                settle(10);
                chk("clocks off", clkOutEnable, 32'h0);
                hard_reset_pin_n <= 1'b1;
            end
            rd(OFS_CTRL, q);
            chk("ctrl reload", q, NVM_CTRL);
            rd(OFS_FLAGS, q);
            chk("flags reset", q, 32'h0);
            rd(OFS_MASK, q);
            chk("mask reset", q, 32'(MASK_RESET));
            chk_act();
        end
        test_done();
    end
endmodule
`default_nettype wire
